//--- hw/tcla_capture.sv
// trace capture engine: sequencer, event buffer, time tag, readout
`timescale 1ns/1ps
`default_nettype none
`include "tcla_defines.svh"
// What this block does
// - sample probes on the chosen sample clock edge and store events
// - sample width is 48 bits, or 96 with the expansion fitted
// - event store is 48 (or 96) bits wide by 256 words
// - one sample can be stored on every sample clock, up to 10 MHz
// - eight comparators, each masked over the full sample width
// - sequence of one to eight ordered levels; recording after the last in start and pre mode
// - at most 255 stored events: qualified samples, plus the completing sample in end and pre mode
// - programmable split of stored events around sequence completion
// - one sync pulse out when the trigger sequence completes
// - any trigger match may raise its own breakpoint request
// - 32-bit time tag counts sample clocks, stored with each event
// - triggers on the same level are ored together
// - start mode keeps next 255; end mode keeps last 255 with trigger
// - pre mode keeps a set count up to and with the trigger, fills the rest after
// - low 16 bits per segment inside or outside two limits qualify
module tcla_capture
  import tcla_pkg::*;
#(
  parameter int SAMPLE_W = `TCLA_BASE_W
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic sample_clk,
  input wire logic [SAMPLE_W-1:0] probe_in,
  input wire tcla_cfg_t cfg_in,
  input wire logic arm,
  input wire logic [`TCLA_PTR_W-1:0] rd_idx,
  output logic arm_busy_reg,
  output logic trace_done_reg,
  output logic [`TCLA_CNT_W-1:0] event_count_reg,
  output logic [SAMPLE_W-1:0] rd_data_reg,
  output logic [`TCLA_TAG_W-1:0] rd_tag_reg,
  output logic seq_sync_reg,
  output logic [`TCLA_NUM_TRIG-1:0] brk_req_reg
);
  // width check
  if (SAMPLE_W != `TCLA_BASE_W && SAMPLE_W != `TCLA_EXP_W) begin : g_bad_w
    $error("SAMPLE_W must be 48 or 96");
  end

  // a crossed level counts once stages two and three agree
  function automatic logic settle(input logic s2, input logic s3,
                                  input logic old);
    settle = (s2 == s3) ? s3 : old;
  endfunction

  // event store, written on the sample clock only
  logic [SAMPLE_W-1:0] mem_data [`TCLA_DEPTH];
  logic [`TCLA_TAG_W-1:0] mem_tag [`TCLA_DEPTH];

  // ---------------- core clock side ----------------
  logic arm_tgl_reg, arm_tgl_next;
  tcla_cfg_t cfg_hold_reg, cfg_hold_next;
  logic [2:0] ack_sy_reg, ack_sy_next;
  logic ack_seen_reg, ack_seen_next;
  logic [2:0] done_sy_reg, done_sy_next;
  logic done_seen_reg, done_seen_next;
  logic arm_busy_next, trace_done_next;
  logic [`TCLA_CNT_W-1:0] event_count_next;
  logic [SAMPLE_W-1:0] rd_data_next;
  logic [`TCLA_TAG_W-1:0] rd_tag_next;
  logic ack_tgl_reg;
  logic done_lvl;
  logic [`TCLA_PTR_W-1:0] wr_ptr_reg;
  logic [`TCLA_CNT_W-1:0] valid_reg;

  always_comb begin
    logic [`TCLA_PTR_W-1:0] addr;
    addr = '0;
    arm_tgl_next = arm_tgl_reg;
    cfg_hold_next = cfg_hold_reg;
    ack_sy_next = {ack_sy_reg[1:0], ack_tgl_reg};
    ack_seen_next = settle(ack_sy_reg[1], ack_sy_reg[2], ack_seen_reg);
    done_sy_next = {done_sy_reg[1:0], done_lvl};
    done_seen_next = settle(done_sy_reg[1], done_sy_reg[2], done_seen_reg);
    // config is held still until the sample side acknowledges it
    if (arm && !arm_busy_reg) begin
      arm_tgl_next = !arm_tgl_reg;
      cfg_hold_next = cfg_in;
    end
    arm_busy_next = arm_tgl_next != ack_seen_next;
    trace_done_next = done_seen_reg && !arm_busy_reg;
    event_count_next = '0;
    rd_data_next = '0;
    rd_tag_next = '0;
    // pointer and count are frozen while the done level stands
    if (done_seen_reg && !arm_busy_reg) begin
      event_count_next = valid_reg;
      addr = wr_ptr_reg - valid_reg[`TCLA_PTR_W-1:0] + rd_idx;
      rd_data_next = mem_data[addr];
      rd_tag_next = mem_tag[addr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      arm_tgl_reg <= 1'b0;
      cfg_hold_reg <= '0;
      ack_sy_reg <= '0;
      ack_seen_reg <= 1'b0;
      done_sy_reg <= '0;
      done_seen_reg <= 1'b0;
      arm_busy_reg <= 1'b0;
      trace_done_reg <= 1'b0;
      event_count_reg <= '0;
      rd_data_reg <= '0;
      rd_tag_reg <= '0;
    end else begin
      arm_tgl_reg <= arm_tgl_next;
      cfg_hold_reg <= cfg_hold_next;
      ack_sy_reg <= ack_sy_next;
      ack_seen_reg <= ack_seen_next;
      done_sy_reg <= done_sy_next;
      done_seen_reg <= done_seen_next;
      arm_busy_reg <= arm_busy_next;
      trace_done_reg <= trace_done_next;
      event_count_reg <= event_count_next;
      rd_data_reg <= rd_data_next;
      rd_tag_reg <= rd_tag_next;
    end
  end

  // ---------------- sample clock side ----------------
  logic [2:0] rst_sy_reg;
  logic rst_s_reg;
  logic [2:0] arm_sy_reg, arm_sy_next;
  logic ack_tgl_next;
  tcla_cfg_t cfg_s_reg, cfg_s_next;
  tcla_state_t state_reg, state_next;
  logic [`TCLA_LVL_W-1:0] lvl_reg, lvl_next;
  logic [`TCLA_PTR_W-1:0] wr_ptr_next;
  logic [`TCLA_CNT_W-1:0] valid_next;
  logic [`TCLA_PTR_W-1:0] post_left_reg, post_left_next;
  logic [`TCLA_TAG_W-1:0] tag_reg, tag_next;
  logic seq_sync_next;
  logic [`TCLA_NUM_TRIG-1:0] brk_req_next;
  logic [SAMPLE_W-1:0] probe_fall_reg;
  logic [SAMPLE_W-1:0] smp;
  logic [`TCLA_NUM_TRIG-1:0] match_w;
  logic lvl_hit_w, qual_w, wr_en, arm_evt, seq_done;

  // reset follows the core reset; hold srst over several sample clocks
  always_ff @(posedge sample_clk) begin
    rst_sy_reg <= {rst_sy_reg[1:0], srst};
    rst_s_reg <= settle(rst_sy_reg[1], rst_sy_reg[2], rst_s_reg);
  end

  // probes are target-synchronous; falling edge caught here
  always_ff @(negedge sample_clk) begin
    probe_fall_reg <= probe_in;
  end
  assign smp = cfg_s_reg.edge_fall ? probe_fall_reg : probe_in;

  tcla_trig_eval #(.SAMPLE_W(SAMPLE_W)) u_eval (
    .smp(smp),
    .cfg(cfg_s_reg),
    .cur_lvl(lvl_reg),
    .match(match_w),
    .lvl_hit(lvl_hit_w),
    .qual_ok(qual_w)
  );

  assign done_lvl = state_reg == TCLA_ST_DONE;
  assign arm_evt = settle(arm_sy_reg[1], arm_sy_reg[2], ack_tgl_reg)
                   != ack_tgl_reg;
  assign seq_done = state_reg == TCLA_ST_SEEK && lvl_hit_w &&
                    lvl_reg == cfg_s_reg.last_level;

  always_comb begin
    logic [`TCLA_PTR_W-1:0] pk;
    logic [`TCLA_CNT_W-1:0] vin;
    pk = (cfg_s_reg.pre_count == '0) ? 8'h01 : cfg_s_reg.pre_count;
    vin = valid_reg + 9'h001;
    arm_sy_next = {arm_sy_reg[1:0], arm_tgl_reg};
    ack_tgl_next = ack_tgl_reg;
    cfg_s_next = cfg_s_reg;
    state_next = state_reg;
    lvl_next = lvl_reg;
    valid_next = valid_reg;
    post_left_next = post_left_reg;
    seq_sync_next = 1'b0;
    wr_en = 1'b0;
    brk_req_next = '0;
    if (state_reg == TCLA_ST_SEEK || state_reg == TCLA_ST_POST) begin
      // per-trigger breakpoint requests
      brk_req_next = match_w & {cfg_s_reg.trig[7].brk_en,
        cfg_s_reg.trig[6].brk_en, cfg_s_reg.trig[5].brk_en,
        cfg_s_reg.trig[4].brk_en, cfg_s_reg.trig[3].brk_en,
        cfg_s_reg.trig[2].brk_en, cfg_s_reg.trig[1].brk_en,
        cfg_s_reg.trig[0].brk_en};
    end
    case (state_reg)
      TCLA_ST_SEEK: begin
        if (seq_done) begin
          seq_sync_next = 1'b1;
          case (cfg_s_reg.mode)
            TCLA_MODE_START: begin
              // only events after completion
              valid_next = '0;
              post_left_next = `TCLA_MAX_POST;
              state_next = TCLA_ST_POST;
            end
            TCLA_MODE_PRE: begin
              // trim history to the programmed count
              wr_en = 1'b1;
              valid_next = (vin > {1'b0, pk}) ? {1'b0, pk} : vin;
              post_left_next = `TCLA_MAX_POST - pk;
              state_next = (pk == `TCLA_MAX_POST) ? TCLA_ST_DONE
                                                  : TCLA_ST_POST;
            end
            default: begin
              // end mode stores the final trigger and stops
              wr_en = 1'b1;
              valid_next = (vin > `TCLA_MAX_EVENTS) ? `TCLA_MAX_EVENTS
                                                    : vin;
              state_next = TCLA_ST_DONE;
            end
          endcase
        end else begin
          if (lvl_hit_w) begin
            lvl_next = lvl_reg + 3'h1;
          end
          // history ring, keeps the newest 255
          if (qual_w && cfg_s_reg.mode != TCLA_MODE_START) begin
            wr_en = 1'b1;
            valid_next = (vin > `TCLA_MAX_EVENTS) ? `TCLA_MAX_EVENTS : vin;
          end
        end
      end
      TCLA_ST_POST: begin
        if (qual_w) begin
          wr_en = 1'b1;
          valid_next = vin;
          post_left_next = post_left_reg - 8'h01;
          if (post_left_reg == 8'h01) begin
            state_next = TCLA_ST_DONE;
          end
        end
      end
      TCLA_ST_IDLE: begin
      end
      TCLA_ST_DONE: begin
      end
      default: state_next = TCLA_ST_IDLE;
    endcase
    wr_ptr_next = wr_en ? wr_ptr_reg + 8'h01 : wr_ptr_reg;
    // interval since the last stored event
    tag_next = wr_en ? '0 : tag_reg + 32'h0000_0001;
    // re-arm wins over everything else
    if (arm_evt) begin
      ack_tgl_next = !ack_tgl_reg;
      cfg_s_next = cfg_hold_reg;
      state_next = TCLA_ST_SEEK;
      lvl_next = '0;
      valid_next = '0;
      wr_ptr_next = '0;
      post_left_next = '0;
      tag_next = '0;
      brk_req_next = '0;
      seq_sync_next = 1'b0;
    end
  end

  always_ff @(posedge sample_clk) begin
    if (rst_s_reg) begin
      arm_sy_reg <= '0;
      ack_tgl_reg <= 1'b0;
      cfg_s_reg <= '0;
      state_reg <= TCLA_ST_IDLE;
      lvl_reg <= '0;
      wr_ptr_reg <= '0;
      valid_reg <= '0;
      post_left_reg <= '0;
      tag_reg <= '0;
      seq_sync_reg <= 1'b0;
      brk_req_reg <= '0;
    end else begin
      arm_sy_reg <= arm_sy_next;
      ack_tgl_reg <= ack_tgl_next;
      cfg_s_reg <= cfg_s_next;
      state_reg <= state_next;
      lvl_reg <= lvl_next;
      wr_ptr_reg <= wr_ptr_next;
      valid_reg <= valid_next;
      post_left_reg <= post_left_next;
      tag_reg <= tag_next;
      seq_sync_reg <= seq_sync_next;
      brk_req_reg <= brk_req_next;
    end
  end

  // store sample and its tag
  always_ff @(posedge sample_clk) begin
    if (wr_en && !rst_s_reg && !arm_evt) begin
      mem_data[wr_ptr_reg] <= smp;
      mem_tag[wr_ptr_reg] <= tag_reg;
    end
  end

  // ---------------- checks ----------------
  sync_one_shot_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) seq_sync_reg |=> !seq_sync_reg)
    else $error("sync pulse longer than one sample clock");
  sync_cause_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) $rose(seq_sync_reg) |->
    $past(state_reg) == TCLA_ST_SEEK && state_reg != TCLA_ST_SEEK)
    else $error("sync pulse without sequence completion");
  event_limit_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) valid_reg <= `TCLA_MAX_EVENTS)
    else $error("more than 255 events held");
  tag_clear_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) wr_en && !arm_evt |=> tag_reg == '0)
    else $error("time tag not cleared after stored event");
  tag_count_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg)
    !rst_s_reg && !wr_en && !arm_evt ##1 !wr_en && !arm_evt
    |-> tag_reg == $past(tag_reg) + 32'h0000_0001)
    else $error("time tag did not advance");
  brk_cause_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) |brk_req_reg |-> $past(|match_w))
    else $error("breakpoint without a trigger match");
  level_step_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) lvl_reg != $past(lvl_reg) |->
    lvl_reg == $past(lvl_reg) + 3'h1 || lvl_reg == '0)
    else $error("sequence level skipped");
  end_stop_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) seq_done && !arm_evt &&
    cfg_s_reg.mode == TCLA_MODE_END |=>
    state_reg == TCLA_ST_DONE && valid_reg != '0 [*2])
    else $error("end mode did not stop with the trigger stored");
  post_stop_a: assert property (@(posedge sample_clk)
    disable iff (srst || rst_s_reg) state_reg == TCLA_ST_POST &&
    post_left_reg == 8'h01 && wr_en && !arm_evt |=>
    state_reg == TCLA_ST_DONE)
    else $error("capture ran past its event budget");
  arm_busy_a: assert property (@(posedge core_clk) disable iff (srst)
    arm && !arm_busy_reg |=> arm_busy_reg)
    else $error("arm not acknowledged as busy");

  start_cov_c: cover property (@(posedge sample_clk) disable iff (rst_s_reg)
    seq_done && cfg_s_reg.mode == TCLA_MODE_START);
  pre_cov_c: cover property (@(posedge sample_clk) disable iff (rst_s_reg)
    seq_done && cfg_s_reg.mode == TCLA_MODE_PRE);
  full_cov_c: cover property (@(posedge sample_clk) disable iff (rst_s_reg)
    state_reg == TCLA_ST_DONE && valid_reg == `TCLA_MAX_EVENTS);
  done_cov_c: cover property (@(posedge core_clk) disable iff (srst)
    $rose(trace_done_reg));
endmodule
`default_nettype wire

//--- hw/tcla_defines.svh
// constants for the trace capture logic analyzer
`ifndef TCLA_DEFINES_SVH
`define TCLA_DEFINES_SVH
`define TCLA_BASE_W 48
`define TCLA_EXP_W 96
`define TCLA_SEG_W 48
`define TCLA_RANGE_W 16
`define TCLA_DEPTH 256
`define TCLA_PTR_W 8
`define TCLA_CNT_W 9
`define TCLA_MAX_EVENTS 9'h0ff
`define TCLA_MAX_POST 8'hff
`define TCLA_TAG_W 32
`define TCLA_NUM_TRIG 8
`define TCLA_LVL_W 3
`endif

//--- hw/tcla_pkg.sv
// types shared by the trace capture logic analyzer
`include "tcla_defines.svh"
package tcla_pkg;
  typedef enum logic [1:0] {
    TCLA_MODE_START,
    TCLA_MODE_END,
    TCLA_MODE_PRE
  } tcla_mode_t;

  typedef enum logic [1:0] {
    TCLA_ST_IDLE,
    TCLA_ST_SEEK,
    TCLA_ST_POST,
    TCLA_ST_DONE
  } tcla_state_t;

  typedef struct packed {
    logic en;
    logic brk_en;
    logic [`TCLA_LVL_W-1:0] level;
    logic [`TCLA_EXP_W-1:0] value;
    logic [`TCLA_EXP_W-1:0] mask;
  } tcla_trig_t;

  typedef struct packed {
    tcla_mode_t mode;
    logic [`TCLA_LVL_W-1:0] last_level;
    logic [`TCLA_PTR_W-1:0] pre_count;
    logic edge_fall;
    logic qual_en;
    logic qual_excl;
    logic [`TCLA_RANGE_W-1:0] qual_lo;
    logic [`TCLA_RANGE_W-1:0] qual_hi;
    tcla_trig_t [`TCLA_NUM_TRIG-1:0] trig;
  } tcla_cfg_t;
endpackage

//--- hw/tcla_trig_eval.sv
// trigger comparators, level match and range qualifier
`timescale 1ns/1ps
`default_nettype none
`include "tcla_defines.svh"
module tcla_trig_eval
  import tcla_pkg::*;
#(
  parameter int SAMPLE_W = `TCLA_BASE_W
) (
  input wire logic [SAMPLE_W-1:0] smp,
  input wire tcla_cfg_t cfg,
  input wire logic [`TCLA_LVL_W-1:0] cur_lvl,
  output logic [`TCLA_NUM_TRIG-1:0] match,
  output logic lvl_hit,
  output logic qual_ok
);
  localparam int NSEG = SAMPLE_W / `TCLA_SEG_W;

  always_comb begin
    logic [`TCLA_RANGE_W-1:0] v;
    logic all_ok;
    logic in_rng;
    v = '0;
    all_ok = 1'b1;
    in_rng = 1'b0;
    match = '0;
    lvl_hit = 1'b0;
    for (int i = 0; i < `TCLA_NUM_TRIG; i++) begin
      // full-width masked compare
      match[i] = cfg.trig[i].en &&
        (((smp ^ cfg.trig[i].value[SAMPLE_W-1:0]) &
          cfg.trig[i].mask[SAMPLE_W-1:0]) == '0);
      // triggers on one level are ored
      if (match[i] && cfg.trig[i].level == cur_lvl) begin
        lvl_hit = 1'b1;
      end
    end
    for (int k = 0; k < NSEG; k++) begin
      // low bits of each segment against the limits
      v = smp[k*`TCLA_SEG_W +: `TCLA_RANGE_W];
      in_rng = (v >= cfg.qual_lo) && (v <= cfg.qual_hi);
      if (cfg.qual_excl ? in_rng : !in_rng) begin
        all_ok = 1'b0;
      end
    end
    qual_ok = !cfg.qual_en || all_ok;
  end
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the trace capture engine
`timescale 1ns/1ps
`default_nettype none
`include "tcla_defines.svh"
module tb_top;
  import tcla_pkg::*;
  localparam int SW = `TCLA_BASE_W;
  localparam logic [SW-1:0] TRIG_V = 48'h7777_0000_0020;
  logic core_clk, srst, arm, sample_clk;
  logic [SW-1:0] probe_in, rd_data_reg;
  tcla_cfg_t cfg_in;
  logic [`TCLA_PTR_W-1:0] rd_idx;
  logic arm_busy_reg, trace_done_reg, seq_sync_reg;
  logic [`TCLA_CNT_W-1:0] event_count_reg;
  logic [`TCLA_TAG_W-1:0] rd_tag_reg;
  logic [`TCLA_NUM_TRIG-1:0] brk_req_reg;
  int bad_count, tests_run, sync_cnt, brk_cnt;

  tcla_capture #(.SAMPLE_W(SW)) tcla_capture_inst (
    .core_clk(core_clk), .srst(srst), .sample_clk(sample_clk),
    .probe_in(probe_in), .cfg_in(cfg_in), .arm(arm), .rd_idx(rd_idx),
    .arm_busy_reg(arm_busy_reg), .trace_done_reg(trace_done_reg),
    .event_count_reg(event_count_reg), .rd_data_reg(rd_data_reg),
    .rd_tag_reg(rd_tag_reg), .seq_sync_reg(seq_sync_reg),
    .brk_req_reg(brk_req_reg)
  );

  tcla_target_model #(.SAMPLE_W(SW)) tcla_target_model_inst (
    .sample_clk(sample_clk), .probe_in(probe_in)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // sample-domain pulses counted on the far edge, away from their update
  always @(negedge sample_clk) begin
    if (seq_sync_reg === 1'b1) sync_cnt++;
    if (brk_req_reg[0] === 1'b1) brk_cnt++;
  end

  task automatic chk(input string what, input logic [SW-1:0] seen,
                     input logic [SW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // bounded wait on busy low (want_done=0) or done high (want_done=1)
  task automatic wait_lvl(input bit want_done);
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge core_clk);
      #2;
      if (want_done ? trace_done_reg === 1'b1 : arm_busy_reg === 1'b0)
        break;
    end
    if (i == 4000) begin
      chk("wait_timeout", 48'h1, 48'h0);
      conclude();
    end
  endtask

  task automatic set_trig(input int k, input logic [2:0] lvl,
                          input logic [SW-1:0] v);
    cfg_in.trig[k].en = 1'b1;
    cfg_in.trig[k].brk_en = 1'b1;
    cfg_in.trig[k].level = lvl;
    cfg_in.trig[k].value = {{(`TCLA_EXP_W-SW){1'b0}}, v};
    cfg_in.trig[k].mask = {{(`TCLA_EXP_W-SW){1'b0}}, {SW{1'b1}}};
  endtask

  task automatic start_capture();
    @(posedge core_clk);
    #2 arm = 1'b1;
    @(posedge core_clk);
    #2 arm = 1'b0;
    chk("busy_up", arm_busy_reg, 48'h1);
    wait_lvl(1'b0);
  endtask

  task automatic rd(input int idx, input logic [SW-1:0] d,
                    input logic [31:0] t, input bit tc);
    @(posedge core_clk);
    #2 rd_idx = idx[7:0];
    repeat (2) @(posedge core_clk);
    #2;
    chk("rd_data", rd_data_reg, d);
    if (tc) chk("rd_tag", rd_tag_reg, t);
  endtask

  // sample side needs several of its own edges inside reset
  task automatic do_reset();
    @(posedge core_clk);
    #2 srst = 1'b1;
    repeat (48) @(posedge core_clk);
    #2 srst = 1'b0;
    repeat (64) @(posedge core_clk);
    #2;
    chk("done_rst", trace_done_reg, 48'h0);
    chk("count_rst", event_count_reg, 48'h0);
    chk("busy_rst", arm_busy_reg, 48'h0);
    chk("rd_rst", rd_data_reg, 48'h0);
  endtask

  initial begin
    bad_count = 0;
    tests_run = 0;
    sync_cnt = 0;
    brk_cnt = 0;
    srst = 1'b1;
    arm = 1'b0;
    rd_idx = '0;
    cfg_in = '0;
    do_reset();
    // end mode, in-range qualifier, gap of one unqualified sample
    cfg_in.mode = TCLA_MODE_END;
    cfg_in.qual_en = 1'b1;
    cfg_in.qual_lo = 16'h0100;
    cfg_in.qual_hi = 16'h01ff;
    set_trig(0, 3'h0, TRIG_V);
    start_capture();
    tcla_target_model_inst.push(48'h1111_0000_0101);
    tcla_target_model_inst.push(48'h1111_0000_0102);
    tcla_target_model_inst.push(48'h2222_0000_0005);
    tcla_target_model_inst.push(48'h1111_0000_01ff);
    tcla_target_model_inst.push(TRIG_V);
    wait_lvl(1'b1);
    chk("count_end", event_count_reg, 48'h4);
    rd(0, 48'h1111_0000_0101, 32'h0, 1'b0);
    rd(1, 48'h1111_0000_0102, 32'h0, 1'b1);
    rd(2, 48'h1111_0000_01ff, 32'h1, 1'b1);
    rd(3, TRIG_V, 32'h0, 1'b1);
    chk("sync_end", sync_cnt, 48'h1);
    chk("brk_end", brk_cnt, 48'h1);
    // start mode, two levels, two triggers ored on the last level
    cfg_in = '0;
    cfg_in.mode = TCLA_MODE_START;
    cfg_in.last_level = 3'h1;
    set_trig(0, 3'h0, 48'ha0a0_0000_0001);
    set_trig(1, 3'h1, 48'ha0a0_0000_0002);
    set_trig(2, 3'h1, 48'ha0a0_0000_0003);
    start_capture();
    tcla_target_model_inst.push(48'ha0a0_0000_0003);
    tcla_target_model_inst.push(48'ha0a0_0000_0001);
    // second trigger of the last level completes it
    tcla_target_model_inst.push(48'ha0a0_0000_0003);
    tcla_target_model_inst.push(48'h3333_0000_0e01);
    tcla_target_model_inst.push(48'h3333_0000_0e02);
    wait_lvl(1'b1);
    chk("count_start", event_count_reg, 48'hff);
    rd(0, 48'h3333_0000_0e01, 32'h0, 1'b0);
    rd(1, 48'h3333_0000_0e02, 32'h0, 1'b1);
    chk("sync_start", sync_cnt, 48'h2);
    chk("brk_start", brk_cnt, 48'h2);
    // pre mode keeps three newest up to the trigger, rest after
    cfg_in = '0;
    cfg_in.mode = TCLA_MODE_PRE;
    cfg_in.pre_count = 8'h03;
    set_trig(0, 3'h0, TRIG_V);
    start_capture();
    tcla_target_model_inst.push(48'h4444_0000_0a01);
    tcla_target_model_inst.push(48'h4444_0000_0a02);
    tcla_target_model_inst.push(TRIG_V);
    tcla_target_model_inst.push(48'h4444_0000_0b01);
    wait_lvl(1'b1);
    chk("count_pre", event_count_reg, 48'hff);
    rd(0, 48'h4444_0000_0a01, 32'h0, 1'b0);
    rd(1, 48'h4444_0000_0a02, 32'h0, 1'b1);
    rd(2, TRIG_V, 32'h0, 1'b1);
    rd(3, 48'h4444_0000_0b01, 32'h0, 1'b1);
    chk("sync_pre", sync_cnt, 48'h3);
    chk("brk_pre", brk_cnt, 48'h3);
    // reset after the run drops the finished trace
    do_reset();
    // falling edge, outside-range qualifier, masked trigger, no break
    cfg_in = '0;
    cfg_in.mode = TCLA_MODE_END;
    cfg_in.edge_fall = 1'b1;
    cfg_in.qual_en = 1'b1;
    cfg_in.qual_excl = 1'b1;
    cfg_in.qual_lo = 16'h8000;
    cfg_in.qual_hi = 16'hffff;
    set_trig(0, 3'h0, TRIG_V);
    cfg_in.trig[0].brk_en = 1'b0;
    cfg_in.trig[0].mask[3:0] = 4'h0;
    tcla_target_model_inst.set_fall(1'b1);
    start_capture();
    tcla_target_model_inst.push(48'h5555_0000_0011);
    tcla_target_model_inst.push(48'h5555_0000_9000);
    tcla_target_model_inst.push(48'h7777_0000_0025);
    wait_lvl(1'b1);
    chk("count_fall", event_count_reg, 48'h2);
    rd(0, 48'h5555_0000_0011, 32'h0, 1'b0);
    rd(1, 48'h7777_0000_0025, 32'h1, 1'b1);
    chk("sync_fall", sync_cnt, 48'h4);
    chk("brk_fall", brk_cnt, 48'h3);
    conclude();
  end
endmodule
`default_nettype wire

//--- sim/tcla_target_model.sv
// target prototype model: free-running sample clock and probe data
`timescale 1ns/1ps
`default_nettype none
`include "tcla_defines.svh"
module tcla_target_model
  import tcla_pkg::*;
#(
  parameter int SAMPLE_W = `TCLA_BASE_W,
  parameter realtime HALF_NS = 80.0
) (
  output logic sample_clk,
  output logic [SAMPLE_W-1:0] probe_in
);
  logic [SAMPLE_W-1:0] pend_q[$];
  logic [11:0] idle_cnt;
  logic fall_mode;

  // target clock runs free; phase offset keeps it apart from core edges
  initial begin
    sample_clk = 1'b0;
    probe_in = '0;
    idle_cnt = 12'h000;
    fall_mode = 1'b0;
    #37;
    forever #(HALF_NS) sample_clk = ~sample_clk;
  end

  // idle data changes every clock so stale values never look valid
  always @(sample_clk) begin
    if (sample_clk) begin
      idle_cnt <= idle_cnt + 12'h001;
      if (pend_q.size() > 0)
        probe_in <= #1 pend_q.pop_front();
      else
        probe_in <= #1 {8'hc3, {(SAMPLE_W-24){1'b0}}, 4'hf, idle_cnt};
    end else if (fall_mode) begin
      // junk after the fall, so a rising-edge sample would be wrong
      probe_in <= #1 ~probe_in;
    end
  end

  task automatic set_fall(input logic f);
    fall_mode = f;
  endtask

  task automatic push(input logic [SAMPLE_W-1:0] v);
    pend_q.push_back(v);
  endtask
endmodule
`default_nettype wire
